//--- core/kbs_pkg.sv
// Constants, key tables and types shared by the keyboard matrix scanner files.
// Assumes a 20 MHz system clock and a 16-column by 8-row switch matrix.

// ==========================================================================
// Package
package kbs_pkg;

	// ======================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_PERIOD_US = 2500;
	localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int SCAN_PERIOD_US = 12500;
	localparam int TICKS_PER_SCAN = SCAN_PERIOD_US / TICK_PERIOD_US;
	localparam int SAMPLE_WINDOW_NS = 1500;
	localparam int SAMPLE_CYCLES = (SAMPLE_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 : SAMPLE_WINDOW_NS / CLK_PERIOD_NS;

	// ======================================================================
	// Matrix geometry and row classes
	localparam int NUM_COLS = 16;
	localparam int NUM_ROWS = 8;
	localparam int NUM_KEYS = NUM_COLS * NUM_ROWS;
	localparam int ROLLOVER_MAX = 3;
	localparam logic [7:0] ROW_REGULAR = 8'h1F;
	localparam logic [7:0] ROW_UNUSED = 8'h60;
	localparam logic [7:0] ROW_MODIFIER = 8'h80;
	localparam logic [NUM_KEYS-1:0] KEY_MOD_MASK = {NUM_COLS{ROW_MODIFIER}};
	localparam logic [NUM_KEYS-1:0] KEY_UNUSED_MASK = {NUM_COLS{ROW_UNUSED}};

	// ======================================================================
	// Tick phases within one group of five
	localparam logic [2:0] PH_SCAN = 3'h0;
	localparam logic [2:0] PH_CHECK = 3'h1;
	localparam logic [2:0] PH_XLATE = 3'h2;
	localparam logic [2:0] PH_LAST = 3'(TICKS_PER_SCAN - 1);

	// ======================================================================
	// Modifier positions, all in row 7
	localparam logic [2:0] MOD_ROW = 3'h7;
	localparam logic [3:0] COL_CTRL_A = 4'h0;
	localparam logic [3:0] COL_CTRL_B = 4'h8;
	localparam logic [3:0] COL_UPPER_A = 4'h1;
	localparam logic [3:0] COL_UPPER_B = 4'h9;
	localparam logic [3:0] COL_SHIFT_A = 4'h2;
	localparam logic [3:0] COL_SHIFT_B = 4'hA;

	// ======================================================================
	// Key tables, column 0 in the top byte; zero means no character
	localparam logic [127:0] MAP_ROW_A = {8'h00, "1234567890", 40'h00};
	localparam logic [127:0] MAP_ROW_A_SHIFT = {8'h00, "!@#$%^&*()", 40'h00};
	localparam logic [127:0] MAP_ROW_B = {8'h1B, "QWERTYUIOP-=\\", 8'h08, 8'h00};
	localparam logic [127:0] MAP_ROW_C = {8'h09, "ASDFGHJKL;[]", 8'h7F, 8'h00, 8'h0D};
	localparam logic [127:0] MAP_ROW_D = {"ZXCVB NM,./'", 8'h0A, 24'h00};
	localparam logic [127:0] MAP_ROW_E = {"1234567890.", 8'h0D, ",-", 16'h00};
	localparam logic [7:0] CASE_BIT = 8'h20;
	localparam logic [7:0] CTRL_MASK = 8'h1F;

	// ======================================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SCAN = 4'b0010,
		ST_CHECK = 4'b0100,
		ST_XLATE = 4'b1000
	} kbs_state_t;

	// Byte of a key table for one column
	function automatic logic [7:0] kbs_table_byte(input logic [127:0] tbl, input logic [3:0] col);
		return tbl[{~col, 3'h0} +: 8];
	endfunction : kbs_table_byte

endpackage : kbs_pkg

//--- core/kbs_keymap.sv
// Translation of a matrix position to a character code.
// Assumes modifier levels come from the key history of the last checked scan of the scanner.
`timescale 1ns/10ps

// ==========================================================================
// Key map
module kbs_keymap import kbs_pkg::*; (
	input wire logic [3:0] col_i, // Column of the key
	input wire logic [2:0] row_i, // Row bit of the key
	input wire logic shift_i, // Either shift key held
	input wire logic upper_i, // Uppercase latch key held
	input wire logic ctrl_i, // Either control key held
	output logic [7:0] code_o // Character code, zero for none
);

	logic [7:0] base;
	logic letter;

	// Table lookup, then case and control folding for letters only
	always_comb begin
		unique case (row_i)
			3'h0: base = shift_i ? kbs_table_byte(MAP_ROW_A_SHIFT, col_i) : kbs_table_byte(MAP_ROW_A, col_i);
			3'h1: base = kbs_table_byte(MAP_ROW_B, col_i);
			3'h2: base = kbs_table_byte(MAP_ROW_C, col_i);
			3'h3: base = kbs_table_byte(MAP_ROW_D, col_i);
			3'h4: base = kbs_table_byte(MAP_ROW_E, col_i);
			default: base = 8'h00; // Unused rows and modifiers give no character
		endcase
		letter = (base >= "A") && (base <= "Z");
		code_o = base;
		if (letter && ctrl_i) begin
			code_o = base & CTRL_MASK;
		end else if (letter && !(shift_i || upper_i)) begin
			code_o = base | CASE_BIT;
		end
	end

endmodule : kbs_keymap

//--- core/kbs_scanner.sv
// Keyboard matrix scanner: tick timer, column scan, history, rollover check and translation.
// Assumes a passive switch matrix on the column address and row pins, and a consumer on the same clock.
//
// How it works
// [R1] Every key position is sampled once per 12.5 ms, so each key is looked at eighty times a second.
// [R2] An accepted key is translated through a table to a character code and handed out, the at-sign giving 40 hex.
// [R3] A key that was already down two scans before is old and never entered again.
// [R4] Each column is sampled once at the end of a 1.5 us window, so a bouncing contact is caught next scan.
// [R5] Up to three regular keys down at once are accepted together.
// [R6] Keys new in different scans come out in press order, keys new in one scan in ascending address order.
// [R7] A scan with four or more regular closures has all its regular closures discarded.
// [R8] Row 7 modifiers are accepted alongside regular keys and never counted toward the limit.
// [R9] A new key is entered only once it is also seen in the next scan.
// [R10] The matrix scan runs on every fifth tick.
// [R11] The next two ticks of the group run the closure count check and translation; the last two ticks start nothing.
// [R12] The matrix answers 16 column addresses with one byte of eight rows each.
// [R13] A closed switch reads as one and an open switch as zero.
// [R14] Row bits 5 and 6 are ignored.
// [R15] The pacing tick recurs every 2.5 ms.
// [R16] Two history bits per position are kept and updated after each complete scan.
`timescale 1ns/10ps

// ==========================================================================
// Scanner top
module kbs_scanner import kbs_pkg::*; #(
	parameter int TICK_CYCLES_P = TICK_CYCLES // Clock cycles per tick
) (
	input wire logic clk_i, // System clock, 20 MHz
	input wire logic resetn_i, // Asynchronous reset, active low
	input wire logic ce_i, // Clock enable, freezes all state when low
	input wire logic [7:0] row_i, // Row pins of the addressed column
	output logic [3:0] col_o, // Column address to the matrix
	output logic col_en_o, // Column address valid, high during a scan
	output logic [7:0] code_o, // Character code
	output logic code_valid_o, // Code valid, held until taken
	input wire logic code_ready_i, // Consumer takes the code
	output logic overflow_o // Last checked scan had too many regular keys
);

	localparam int TICK_W = $clog2(TICK_CYCLES_P + 1);
	localparam int WIN_M1 = SAMPLE_CYCLES - 1;
	localparam logic [4:0] WIN_LAST = 5'(SAMPLE_CYCLES - 1);

	kbs_state_t state_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic tick_q;
	logic [2:0] phase_q;
	logic [7:0] row_s1_q, row_s2_q, row_s3_q, row_filt_q;
	logic [3:0] col_q;
	logic [4:0] win_q;
	logic col_en_q;
	logic [NUM_KEYS-1:0] cur_q, hist1_q, hist2_q, pend_q, eff_w;
	logic [6:0] idx_q;
	logic [7:0] code_q, map_w, count_w;
	logic code_valid_q, ovf_q, ovf_w, sample_w, scan_last_w, xl_step_w, hit_w;

	// Closed regular keys of one scan, modifiers and unused rows left out
	function automatic logic [7:0] kbs_count_regular(input logic [NUM_KEYS-1:0] v);
		logic [7:0] n;
		n = 8'h00;
		for (int c = 0; c < NUM_COLS; c++) begin
			for (int r = 0; r < NUM_ROWS; r++) begin
				if (ROW_REGULAR[r] && v[c*NUM_ROWS+r]) begin
					n = n + 8'h01;
				end
			end
		end
		return n;
	endfunction : kbs_count_regular

	// ======================================================================
	// Tick timer and phase within the group of five
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (ce_i) begin
			if (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1)) begin
				tick_cnt_q <= '0; // R15
				tick_q <= 1'b1;
			end else begin
				tick_cnt_q <= tick_cnt_q + TICK_W'(1);
				tick_q <= 1'b0;
			end
		end
	end

	// Phase wraps after five ticks, giving one scan per 12.5 ms
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_q <= PH_SCAN;
		end else if (ce_i && tick_q) begin
			phase_q <= (phase_q == PH_LAST) ? PH_SCAN : phase_q + 3'h1; // R1 R10
		end
	end

	// ======================================================================
	// Row pin synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			row_s1_q <= 8'h00;
			row_s2_q <= 8'h00;
			row_s3_q <= 8'h00;
			row_filt_q <= 8'h00;
		end else if (ce_i) begin
			row_s1_q <= row_i;
			row_s2_q <= row_s1_q;
			row_s3_q <= row_s2_q;
			if (row_s2_q == row_s3_q) begin
				row_filt_q <= row_s3_q;
			end
		end
	end

	// ======================================================================
	// Sequencer; a tick that finds it busy is skipped
	assign scan_last_w = (state_q == ST_SCAN) && (col_q == 4'hF) && (win_q == WIN_LAST);
	assign xl_step_w = (state_q == ST_XLATE) && (!code_valid_q || code_ready_i);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_IDLE;
			col_en_q <= 1'b0;
		end else if (ce_i) begin
			unique case (state_q)
				ST_IDLE: begin
					if (tick_q && phase_q == PH_SCAN) begin
						state_q <= ST_SCAN; // R10
						col_en_q <= 1'b1;
					end else if (tick_q && phase_q == PH_CHECK) begin
						state_q <= ST_CHECK; // R11
					end else if (tick_q && phase_q == PH_XLATE) begin
						state_q <= ST_XLATE; // R11
					end
				end
				ST_SCAN: begin
					if (scan_last_w) begin
						state_q <= ST_IDLE;
						col_en_q <= 1'b0;
					end
				end
				ST_CHECK: begin
					state_q <= ST_IDLE;
				end
				ST_XLATE: begin
					if (xl_step_w && idx_q == 7'h7F) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE; // Illegal one-hot code recovers
					col_en_q <= 1'b0;
				end
			endcase
		end
	end

	// ======================================================================
	// Column walk: each column held for the sample window, sampled once at its end
	assign sample_w = (state_q == ST_SCAN) && (win_q == WIN_LAST);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			col_q <= 4'h0;
			win_q <= 5'h00;
		end else if (ce_i) begin
			if (state_q != ST_SCAN) begin
				col_q <= 4'h0;
				win_q <= 5'h00;
			end else if (win_q == WIN_LAST) begin
				win_q <= 5'h00; // R4
				col_q <= col_q + 4'h1; // R12
			end else begin
				win_q <= win_q + 5'h01;
			end
		end
	end

	// Short sampling instant; a contact bouncing open here is simply seen next scan
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur_q <= '0;
		end else if (ce_i && sample_w) begin
			cur_q[{col_q, 3'h0} +: 8] <= row_filt_q & ~ROW_UNUSED; // R4 R13 R14
		end
	end

	// ======================================================================
	// Closure count check and history update
	assign count_w = kbs_count_regular(cur_q); // R8
	assign ovf_w = count_w > 8'(ROLLOVER_MAX); // R5
	assign eff_w = ovf_w ? (cur_q & KEY_MOD_MASK) : cur_q; // R7 R8

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hist1_q <= '0;
			hist2_q <= '0;
			ovf_q <= 1'b0;
		end else if (ce_i && state_q == ST_CHECK) begin
			hist2_q <= hist1_q; // R16
			hist1_q <= eff_w; // R16
			ovf_q <= ovf_w; // R7
		end
	end

	// Pending keys: seen in the last two scans but not in the one before
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pend_q <= '0;
		end else if (ce_i) begin
			if (state_q == ST_CHECK) begin
				pend_q <= eff_w & hist1_q & ~hist2_q; // R3 R5 R9
			end else if (xl_step_w) begin
				pend_q[idx_q] <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Translation walk in ascending address order, stalled by the consumer
	assign hit_w = pend_q[idx_q] && (map_w != 8'h00);

	kbs_keymap u_keymap (
		.col_i(idx_q[6:3]),
		.row_i(idx_q[2:0]),
		.shift_i(hist1_q[{COL_SHIFT_A, MOD_ROW}] | hist1_q[{COL_SHIFT_B, MOD_ROW}]),
		.upper_i(hist1_q[{COL_UPPER_A, MOD_ROW}] | hist1_q[{COL_UPPER_B, MOD_ROW}]),
		.ctrl_i(hist1_q[{COL_CTRL_A, MOD_ROW}] | hist1_q[{COL_CTRL_B, MOD_ROW}]),
		.code_o(map_w)
	);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx_q <= 7'h00;
		end else if (ce_i) begin
			if (state_q != ST_XLATE) begin
				idx_q <= 7'h00;
			end else if (xl_step_w) begin
				idx_q <= idx_q + 7'h01; // R6
			end
		end
	end

	// Output holds until taken, so nothing is lost to a slow consumer
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			code_q <= 8'h00;
			code_valid_q <= 1'b0;
		end else if (ce_i) begin
			if (xl_step_w && hit_w) begin
				code_q <= map_w; // R2
				code_valid_q <= 1'b1;
			end else if (code_ready_i) begin
				code_valid_q <= 1'b0;
			end
		end
	end

	assign col_o = col_q;
	assign col_en_o = col_en_q;
	assign code_o = code_q;
	assign code_valid_o = code_valid_q;
	assign overflow_o = ovf_q;

	// ======================================================================
	// Assertions
	a_tick_spacing: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R15
		tick_q |=> (!tick_q) [*8]) else $error("ticks too close");

	a_scan_fifth: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R10
		(state_q == ST_SCAN && $past(state_q) == ST_IDLE) |-> $past(tick_q) && $past(phase_q) == PH_SCAN)
		else $error("scan started off the fifth tick");

	a_followup_tick: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R11
		(state_q == ST_CHECK) |-> $past(tick_q) && $past(phase_q) == PH_CHECK) else $error("check off its tick");

	a_window_hold: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R4
		(state_q == ST_SCAN && win_q == 5'h00) |-> ##WIN_M1 (sample_w && $stable(col_q)))
		else $error("sample window wrong length");

	a_scan_complete: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R1
		(state_q == ST_SCAN && col_q == 4'hF && win_q == WIN_LAST) |=> state_q == ST_IDLE && !col_en_o && col_q == 4'h0)
		else $error("scan did not end after column 15");

	a_rows_masked: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R14
		(cur_q & KEY_UNUSED_MASK) == '0) else $error("unused row stored");

	a_no_reentry: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R3
		(state_q == ST_CHECK) |=> (pend_q & $past(hist2_q)) == '0) else $error("old key re-entered");

	a_confirm_two: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R9
		(state_q == ST_CHECK) |=> (pend_q & ~$past(hist1_q)) == '0 && (pend_q & ~hist1_q) == '0)
		else $error("key entered without confirmation");

	a_rollover_ok: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R5
		(state_q == ST_CHECK && count_w <= 8'h03) |=> pend_q == ($past(cur_q) & $past(hist1_q) & ~$past(hist2_q)) && !ovf_q)
		else $error("rollover keys dropped");

	a_overflow_drop: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R7
		(state_q == ST_CHECK && count_w >= 8'h04) |=> (pend_q & ~KEY_MOD_MASK) == '0 && ovf_q)
		else $error("overflow scan not discarded");

	a_mods_kept: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R8
		(state_q == ST_CHECK) |=> (hist1_q & KEY_MOD_MASK) == ($past(cur_q) & KEY_MOD_MASK))
		else $error("modifier lost in check");

	a_ascending: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R6
		(state_q == ST_XLATE) |-> (pend_q & ((128'h1 << idx_q) - 128'h1)) == '0) else $error("walk out of order");

	a_code_out: assert property (@(posedge clk_i iff ce_i) disable iff (!resetn_i) // R2
		(xl_step_w && hit_w) |=> code_valid_o && code_o == $past(map_w) && code_o != 8'h00)
		else $error("code not presented");

endmodule : kbs_scanner

//--- test/kbs_matrix_model.sv
// Model of the passive 16 by 8 key switch matrix behind the scanner's column address.
// Assumes the bench sets the pressed keys as one bit per position, index {col,row}.
`timescale 1ns/10ps

// ==========================================================================
// Matrix model
module kbs_matrix_model (
	input wire logic clk_i, // System clock
	input wire logic [3:0] col_i, // Column address from the scanner
	input wire logic col_en_i, // Column address valid
	input wire logic [127:0] keys_i, // Pressed keys, 1 = closed
	output logic [7:0] row_o // Row pins back to the scanner
);
	logic [7:0] col_byte;

	// One byte per column, closed reads as one, rows 5 and 6 wired high
	assign col_byte = {keys_i[{col_i, 3'h7}], 2'b11, keys_i[{col_i, 3'h0} +: 5]};

	// Unaddressed matrix gives a toggling pattern, so a stale value is never read as valid
	always @(posedge clk_i) begin
		if (col_en_i) begin
			row_o <= col_byte;
		end else begin
			row_o <= ~row_o;
		end
	end

	initial row_o = 8'h00;

endmodule : kbs_matrix_model

//--- test/kbs_scanner_tb.sv
// Self-checking bench for the keyboard matrix scanner with a matrix model on its column side.
// Assumes a shortened tick of 520 cycles; the scan period is derived from it.
`timescale 1ns/10ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

// ==========================================================================
// Bench top
module kbs_scanner_tb;
	import kbs_pkg::*;
	localparam int TK = 520;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic ce_i = 1'b1;
	logic [7:0] row_i;
	logic [3:0] col_o;
	logic col_en_o;
	logic [7:0] code_o;
	logic code_valid_o;
	logic code_ready_i = 1'b0;
	logic overflow_o;
	logic [127:0] keys = '0;
	logic [7:0] q[$];
	logic [7:0] e;
	int n_fail = 0;
	int n_checks = 0;
	int seed = 68;
	int cyc = 0;
	int last_rise = 0;
	int hi_cnt = 0;
	logic en_q = 1'b0;
	bit ce_rnd = 1'b0;
	logic [127:0] rk;
	int n;

	always #25 clk_i = ~clk_i;

	kbs_scanner #(.TICK_CYCLES_P(TK)) i_kbs_scanner (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.row_i(row_i), .col_o(col_o), .col_en_o(col_en_o), .code_o(code_o), .code_valid_o(code_valid_o),
		.code_ready_i(code_ready_i), .overflow_o(overflow_o));
	kbs_matrix_model i_kbs_matrix_model (.clk_i(clk_i), .col_i(col_o), .col_en_i(col_en_o),
		.keys_i(keys), .row_o(row_i));

	// ======================================================================
	// Consumer stalls at random so codes must stand until taken
	always @(posedge clk_i) begin
		#2 code_ready_i = 1'($random(seed));
	end

	// Clock enable drops one cycle in eight once the enable scenarios start
	always @(posedge clk_i) begin
		#2 ce_i = !ce_rnd || (($random(seed) & 7) != 0);
	end

	// Codes leaving the scanner against the oldest note
	always @(posedge clk_i) begin
		if (ce_i === 1'b1 && code_valid_o === 1'b1 && code_ready_i === 1'b1) begin
			e = (q.size() > 0) ? q.pop_front() : 8'hXX;
			`CHK("code", e, code_o)
		end
	end

	// Scan period, column order and dwell of each column, counted in enabled cycles only
	always @(posedge clk_i) begin
		if (ce_i === 1'b1) begin
			cyc++;
			en_q <= col_en_o;
			if (col_en_o === 1'b1 && !en_q) begin
				if (last_rise > 0) `CHK("scan period", 5 * TK, cyc - last_rise)
				last_rise = cyc;
				hi_cnt = 0;
			end
			if (col_en_o === 1'b1) begin
				if (hi_cnt % 30 == 15) `CHK("column", 4'(hi_cnt / 30), col_o)
				hi_cnt++;
			end
			if (col_en_o === 1'b0 && en_q) `CHK("scan length", 480, hi_cnt)
		end
	end

	// Waits for the end of the next scan, bounded
	task automatic wait_scan();
		int k;
		k = 0;
		while (col_en_o !== 1'b1 && k < 6000) begin @(posedge clk_i); k++; end
		while (col_en_o === 1'b1 && k < 6000) begin @(posedge clk_i); k++; end
		#2;
	endtask : wait_scan

	// Holds a key set through some scans, lets translation finish, then releases
	task automatic run(input logic [127:0] m, input int hold, input string nm);
		keys = m;
		repeat (hold) wait_scan();
		repeat (1000) @(posedge clk_i);
		#2 keys = '0;
		wait_scan();
		$display("test %s done", nm);
	endtask : run

	function automatic logic [127:0] k(input int c, input int r);
		logic [127:0] v;
		v = '0;
		v[c * 8 + r] = 1'b1;
		return v;
	endfunction : k

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	// ======================================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		#2 resetn_i = 1'b1;
		wait_scan();
		// Held key enters once
		q.push_back(8'h31);
		run(k(1, 0), 3, "held key");
		// Three keys in one scan, address order
		q.push_back(8'h31); q.push_back(8'h32); q.push_back(8'h33);
		run(k(3, 0) | k(1, 0) | k(2, 0), 2, "rollover");
		// Four keys rejected, then three accepted
		keys = k(1, 0) | k(2, 0) | k(3, 0) | k(4, 0);
		repeat (2) wait_scan();
		repeat (100) @(posedge clk_i);
		`CHK("overflow set", 1'b1, overflow_o)
		// Fourth key lifted straight away, the other three stay down
		q.push_back(8'h31); q.push_back(8'h32); q.push_back(8'h33);
		run(k(1, 0) | k(2, 0) | k(3, 0), 2, "overflow");
		`CHK("overflow clear", 1'b0, overflow_o)
		// Shift with three regular keys stays under the limit
		q.push_back(8'h21); q.push_back(8'h40); q.push_back(8'h23);
		run(k(2, 7) | k(1, 0) | k(2, 0) | k(3, 0), 2, "modifier");
		// Press order across scans beats address order; a plain letter comes out lower case
		keys = k(5, 0);
		wait_scan();
		q.push_back(8'h35);
		q.push_back(8'h65);
		q.push_back(8'h34);
		run(k(5, 0) | k(4, 0) | k(3, 1), 2, "press order");
		// A closure seen in one scan only is dropped
		run(k(6, 0), 1, "one scan");
		// Random digit sets of up to three keys
		repeat (2) begin
			rk = '0;
			n = 0;
			for (int c = 1; c <= 10; c++) begin
				if (n < 3 && ($random(seed) & 3) == 0) begin
					rk[c * 8] = 1'b1;
					n++;
					q.push_back((c == 10) ? 8'h30 : 8'(8'h30 + c));
				end
			end
			if (n == 0) begin
				rk = k(7, 0);
				q.push_back(8'h37);
			end
			run(rk, 2, "random");
		end
		// Clock enable dropped at random from here on; uppercase latch, then control
		ce_rnd = 1'b1;
		q.push_back(8'h51);
		q.push_back(8'h53);
		run(k(1, 7) | k(1, 1) | k(2, 2), 2, "uppercase latch");
		q.push_back(8'h01);
		run(k(0, 7) | k(1, 2), 2, "control");
		`CHK("codes missing", 0, q.size())
		test_done();
	end

	// Watchdog: about 34 scans of 2600 enabled cycles, plus the slowed enable scenarios
	initial begin
		repeat (98000) @(posedge clk_i);
		n_fail++;
		test_done();
	end

endmodule : kbs_scanner_tb
